// file: bench/cid_core_props.sv
/*
 * Port-level checker for cid_core: execution length, flush, pulses.
 * Bound to cid_core; sees only its top-level ports.
 */
`timescale 1ns/1ps
module cid_core_props (
    input wire logic CLK_I,
    input wire logic RST_B_I,
    input wire logic HREADYOUT_O,
    input wire logic HRESP_O,
    input wire logic PRESCALER_ON_TIMER_I,
    input wire logic WDT_RESTART_O,
    input wire logic PRESCALER_CLEAR_O,
    input wire logic SLEEP_O,
    input wire logic BUSY_O
);
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RST_B_I);

    bus_okay_a: assert property (HREADYOUT_O && !HRESP_O)
        else $error("slave stalled or answered with an error");
    busy_len_a: assert property ($rose(BUSY_O) |-> BUSY_O [*4])
        else $error("instruction cycle shorter than four clocks");
    // either a plain cycle or one cycle plus one flushed cycle
    busy_end_a: assert property ($rose(BUSY_O) |-> ##4
        (!BUSY_O or BUSY_O [*4] ##1 !BUSY_O))
        else $error("execution neither one nor two instruction cycles");
    pulse_end_a: assert property ((WDT_RESTART_O || SLEEP_O) |-> $fell(BUSY_O))
        else $error("watchdog or sleep pulse not at end of execution");
    sleep_wdt_a: assert property (SLEEP_O |-> WDT_RESTART_O)
        else $error("standby entry without watchdog restart");
    wdt_once_a: assert property (WDT_RESTART_O |=> !WDT_RESTART_O)
        else $error("watchdog restart pulse longer than one clock");
    sleep_once_a: assert property (SLEEP_O |=> !SLEEP_O)
        else $error("sleep pulse longer than one clock");
    pre_assign_a: assert property (PRESCALER_CLEAR_O |->
        $past(PRESCALER_ON_TIMER_I) && $fell(BUSY_O))
        else $error("prescaler cleared while not assigned to timer");
    pre_once_a: assert property (PRESCALER_CLEAR_O |=> !PRESCALER_CLEAR_O)
        else $error("prescaler clear pulse longer than one clock");
endmodule

bind cid_core cid_core_props cid_core_props_inst (
    .CLK_I(CLK_I),
    .RST_B_I(RST_B_I),
    .HREADYOUT_O(HREADYOUT_O),
    .HRESP_O(HRESP_O),
    .PRESCALER_ON_TIMER_I(PRESCALER_ON_TIMER_I),
    .WDT_RESTART_O(WDT_RESTART_O),
    .PRESCALER_CLEAR_O(PRESCALER_CLEAR_O),
    .SLEEP_O(SLEEP_O),
    .BUSY_O(BUSY_O)
);

// file: bench/tb_cid_core.sv
/*
 * Self-checking bench for cid_core: runs instructions through the
 * AHB-Lite register port and checks results, flags, timing and pulses.
 * Assumes the zero-wait slave behaviour and register map of the core.
 */
`timescale 1ns/1ps
module tb_cid_core;
    import cid_pkg::*;
    logic CLK_I = 1'b0;
    logic RST_B_I = 1'b0;
    logic HSEL_I = 1'b0;
    logic [7:0] HADDR_I = 8'h00;
    logic [1:0] HTRANS_I = 2'h0;
    logic HWRITE_I = 1'b0;
    logic [31:0] HWDATA_I = 32'h0;
    logic [7:0] PORT_PINS_I = 8'h00;
    logic PRESCALER_ON_TIMER_I = 1'b0;
    logic [31:0] HRDATA_O;
    logic HREADYOUT_O, HRESP_O, WDT_RESTART_O, PRESCALER_CLEAR_O, SLEEP_O, BUSY_O;
    logic [7:0] PORT_LATCH_O;
    logic [31:0] exp_q[$];
    logic rd_ph = 1'b0;
    int error_cnt = 0, checks = 0, seed = 65008, guard = 0, wdt_n = 0, pre_n = 0, slp_n = 0;
    logic [7:0] acc = 8'h00, v, r, k;
    logic [6:0] f;
    logic [2:0] b, b2, bb;
    logic d;
    logic [12:0] pc = 13'h0, t;
    logic [4:0] st = 5'h18;
    logic [13:0] rw[3];

    always #2.5 CLK_I = ~CLK_I;

    cid_core cid_core_inst (
        .CLK_I(CLK_I),
        .RST_B_I(RST_B_I),
        .HSEL_I(HSEL_I),
        .HADDR_I(HADDR_I),
        .HTRANS_I(HTRANS_I),
        .HWRITE_I(HWRITE_I),
        .HSIZE_I(3'h2),
        .HWDATA_I(HWDATA_I),
        .HREADY_I(HREADYOUT_O),
        .HRDATA_O(HRDATA_O),
        .HREADYOUT_O(HREADYOUT_O),
        .HRESP_O(HRESP_O),
        .PORT_PINS_I(PORT_PINS_I),
        .PRESCALER_ON_TIMER_I(PRESCALER_ON_TIMER_I),
        .PORT_LATCH_O(PORT_LATCH_O),
        .WDT_RESTART_O(WDT_RESTART_O),
        .PRESCALER_CLEAR_O(PRESCALER_CLEAR_O),
        .SLEEP_O(SLEEP_O),
        .BUSY_O(BUSY_O)
    );

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want)
        begin
            error_cnt++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask

    task automatic step();
        @(posedge CLK_I);
        guard++;
        if (guard > 60)
        begin
            error_cnt++;
            tally_and_finish();
        end
    endtask

    // read results are compared here, at the data phase edge
    always @(posedge CLK_I)
    begin
        if (rd_ph && HREADYOUT_O === 1'b1)
            check(HRDATA_O, exp_q.pop_front());
        wdt_n += (WDT_RESTART_O === 1'b1);
        pre_n += (PRESCALER_CLEAR_O === 1'b1);
        slp_n += (SLEEP_O === 1'b1);
    end

    task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] dt);
        guard = 0;
        HSEL_I <= 1'b1;
        HTRANS_I <= 2'h2;
        HWRITE_I <= w;
        HADDR_I <= ad;
        do
            step();
        while (HREADYOUT_O !== 1'b1);
        HSEL_I <= 1'b0;
        HTRANS_I <= 2'h0;
        HWDATA_I <= dt;
        rd_ph <= !w;
        do
            step();
        while (HREADYOUT_O !== 1'b1);
        rd_ph <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
        bus(1'b1, ad, dt);
    endtask

    task automatic rd(input logic [7:0] ad, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, ad, 32'h0);
    endtask

    // runs one word and measures how long the core stays busy
    task automatic ex(input logic [13:0] w, input int cyc);
        int n;
        n = 0;
        bus(1'b1, A_INSTR, {18'h0, w});
        guard = 0;
        do
        begin
            step();
            n += (BUSY_O === 1'b1);
        end
        while (BUSY_O === 1'b1);
        check(n, cyc);
        pc = pc + 13'(cyc / 4);
    endtask

    function automatic logic [7:0] alu(input logic [7:0] x, input logic [7:0] y, input logic ci);
        logic [8:0] s;
        logic [4:0] h;
        s = x + y + ci;
        h = x[3:0] + y[3:0] + ci;
        st[2:0] = {s[7:0] == 8'h00, h[4], s[8]};
        return s[7:0];
    endfunction

    initial
    begin
        repeat (12) @(posedge CLK_I);
        RST_B_I <= 1'b1;
        @(posedge CLK_I);
        rd(A_STATUS, 32'h18);
        rd(8'h40, 32'h0);
        // first pass uses zeros so the zero and no-borrow cases appear
        for (int i = 0; i < 6; i++)
        begin
            acc = (i == 0) ? 8'h00 : 8'($random(seed));
            k = (i == 0) ? 8'h00 : 8'($random(seed));
            wr(A_ACC, {24'h0, acc});
            ex({CLS_LIT, LIT_ADD, 1'b0, k}, 4);
            acc = alu(acc, k, 1'b0);
            rd(A_STATUS, {27'h0, st});
            ex({CLS_LIT, LIT_SUB, 1'b0, k}, 4);
            acc = alu(k, ~acc, 1'b1);
            rd(A_ACC, {24'h0, acc});
            rd(A_STATUS, {27'h0, st});
            ex({CLS_LIT, LIT_OR, k}, 4);
            acc = acc | k;
            st[2] = (acc == 8'h00);
            rd(A_ACC, {24'h0, acc});
            rd(A_STATUS, {27'h0, st});
        end
        for (int i = 0; i < 4; i++)
        begin
            f = {2'b01, 5'($random(seed))};
            v = 8'($random(seed));
            b = 3'($random(seed));
            b2 = 3'($random(seed));
            d = i[0];
            wr(A_FILE_SEL, {25'h0, f});
            wr(A_FILE_DATA, {24'h0, v});
            ex({CLS_BIT, BIT_CLEAR, b, f}, 4);
            v[b] = 1'b0;
            rd(A_FILE_DATA, {24'h0, v});
            ex({CLS_BIT, BIT_SET, b2, f}, 4);
            v[b2] = 1'b1;
            rd(A_FILE_DATA, {24'h0, v});
            rd(A_STATUS, {27'h0, st});
            for (int j = 0; j < 2; j++)
            begin
                bb = j ? b2 : b;
                ex({CLS_BIT, BIT_SKIP_LOW, bb, f}, v[bb] ? 4 : 8);
                ex({CLS_BIT, BIT_SKIP_HIGH, bb, f}, v[bb] ? 8 : 4);
            end
            rd(A_PC, {19'h0, pc});
            rd(A_STATUS, {27'h0, st});
            ex({CLS_BYTE, SUB_ADD_REG, d, f}, 4);
            r = alu(acc, v, 1'b0);
            if (d)
                v = r;
            else
                acc = r;
            rd(A_ACC, {24'h0, acc});
            rd(A_FILE_DATA, {24'h0, v});
            rd(A_STATUS, {27'h0, st});
            ex({CLS_BYTE, SUB_XOR_REG, !d, f}, 4);
            r = acc ^ v;
            st[2] = (r == 8'h00);
            if (d)
                acc = r;
            else
                v = r;
            rd(A_ACC, {24'h0, acc});
            rd(A_FILE_DATA, {24'h0, v});
            rd(A_STATUS, {27'h0, st});
        end
        // port source must come from the pins, not from the latch
        v = 8'($random(seed));
        PORT_PINS_I <= ~v;
        wr(A_FILE_SEL, {25'h0, FA_PORT});
        wr(A_FILE_DATA, {24'h0, v});
        ex({CLS_BIT, BIT_SET, b, FA_PORT}, 4);
        v = ~v;
        v[b] = 1'b1;
        rd(A_FILE_DATA, {24'h0, v});
        check(PORT_LATCH_O, v);
        PRESCALER_ON_TIMER_I <= 1'b1;
        ex({CLS_BIT, BIT_SET, b, FA_TIMER_ZERO}, 4);
        ex({CLS_BYTE, SUB_ADD_REG, 1'b0, FA_TIMER_ZERO}, 4);
        acc = alu(acc, 8'h01 << b, 1'b0);
        PRESCALER_ON_TIMER_I <= 1'b0;
        ex({CLS_BIT, BIT_CLEAR, b, FA_TIMER_ZERO}, 4);
        rd(A_ACC, {24'h0, acc});
        check(pre_n, 1);
        ex(W_STANDBY, 4);
        st[4:3] = 2'b10;
        rd(A_STATUS, {27'h0, st});
        ex(W_KICK, 4);
        st[4:3] = 2'b11;
        rd(A_STATUS, {27'h0, st});
        check(wdt_n, 2);
        check(slp_n, 1);
        t = pc + 13'h1;
        k = 8'($random(seed));
        ex({CLS_JUMP, 4'h0, k}, 8);
        pc = {pc[12:11], 3'h0, k};
        rd(A_STACK_TOP, {19'h0, t});
        rd(A_PC, {19'h0, pc});
        k = 8'($random(seed));
        rw[0] = W_RETURN;
        rw[1] = W_INT_EXIT;
        rw[2] = {CLS_LIT, LIT_EXIT, 2'h0, k};
        for (int i = 0; i < 3; i++)
        begin
            t = 13'($random(seed));
            wr(A_STACK_TOP, {19'h0, t});
            ex(rw[i], 8);
            pc = t;
            rd(A_PC, {19'h0, pc});
        end
        rd(A_ACC, {24'h0, k});
        step();
        check(exp_q.size(), 0);
        tally_and_finish();
    end
endmodule

// file: verilog/cid_alu.sv
/*
 * Combinational byte arithmetic unit: add, immediate minus accumulator,
 * logic ops and single bit clear or set.
 * Assumes the caller decides which flags are actually kept.
 */
`timescale 1ns/1ps
module cid_alu (
    input wire cid_pkg::cid_alu_op_t op_i,
    input wire logic [7:0] a_i,
    input wire logic [7:0] b_i,
    input wire logic [2:0] bit_i,
    output logic [7:0] res_o,
    output logic c_o,
    output logic dc_o,
    output logic z_o
);
    import cid_pkg::*;

    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] onehot;

    always_comb
    begin
        sum = {1'b0, a_i} + {1'b0, b_i};
        nib = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]};
        onehot = 8'h01 << bit_i;
        res_o = a_i;
        case (op_i)
            ALU_ADD:
            begin
                res_o = sum[7:0];
            end
            ALU_SUB:
            begin
                // two's complement: carry set means no borrow
                sum = {1'b0, a_i} + {1'b0, ~b_i} + 9'h001;
                nib = {1'b0, a_i[3:0]} + {1'b0, ~b_i[3:0]} + 5'h01;
                res_o = sum[7:0];
            end
            ALU_AND: res_o = a_i & b_i;
            ALU_OR: res_o = a_i | b_i;
            ALU_XOR: res_o = a_i ^ b_i;
            ALU_BCLR: res_o = a_i & ~onehot;
            ALU_BSET: res_o = a_i | onehot;
            default: res_o = a_i;
        endcase
        c_o = sum[8];
        dc_o = nib[4];
        z_o = (res_o == 8'h00);
    end

endmodule

// file: verilog/cid_core.sv
/*
 * Decode and execute unit of the 8-bit accumulator core with its register
 * file, reached by software over AHB-Lite (one slave, word transfers).
 * Assumes pin levels, the prescaler assignment and bus inputs are
 * synchronous to CLK_I; the watchdog, timer and sleep logic sit outside.
 */
// Decided for this implementation: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module cid_core (
    input wire logic CLK_I,
    input wire logic RST_B_I,
    input wire logic HSEL_I,
    input wire logic [7:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    input wire logic [7:0] PORT_PINS_I,
    input wire logic PRESCALER_ON_TIMER_I,
    output logic [7:0] PORT_LATCH_O,
    output logic WDT_RESTART_O,
    output logic PRESCALER_CLEAR_O,
    output logic SLEEP_O,
    output logic BUSY_O
);
    import cid_pkg::*;

    typedef struct packed {
        cid_state_t st;
        logic [1:0] ph;
        logic [13:0] ir;
        logic [7:0] acc;
        logic c;
        logic dc;
        logic z;
        logic expiry;
        logic sleep_entry;
        logic [12:0] pc;
        logic [12:0] tos;
        logic [6:0] fsel;
        logic [127:0][7:0] file;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
        logic wdt;
        logic pre;
        logic slp;
    } cid_core_state_t;

    localparam cid_core_state_t RESET_STATE = '{
        st: ST_IDLE,
        ph: 2'h0,
        ir: 14'h0000,
        acc: 8'h00,
        c: 1'b0,
        dc: 1'b0,
        z: 1'b0,
        expiry: RST_EXPIRY,
        sleep_entry: RST_SLEEP_ENTRY,
        pc: 13'h0000,
        tos: 13'h0000,
        fsel: 7'h00,
        file: '0,
        wr_pend: 1'b0,
        wr_addr: 8'h00,
        rdata: 32'h0000_0000,
        wdt: 1'b0,
        pre: 1'b0,
        slp: 1'b0
    };

    cid_core_state_t s;
    cid_core_state_t next_s;

    // bit 3 flags a mapped offset, low bits give the register index
    function automatic logic [3:0] dec_reg(input logic [7:0] addr);
        if (addr == A_INSTR)
            dec_reg = {1'b1, R_INSTR};
        else if (addr == A_ACC)
            dec_reg = {1'b1, R_ACC};
        else if (addr == A_STATUS)
            dec_reg = {1'b1, R_STATUS};
        else if (addr == A_PC)
            dec_reg = {1'b1, R_PC};
        else if (addr == A_STACK_TOP)
            dec_reg = {1'b1, R_STACK_TOP};
        else if (addr == A_FILE_SEL)
            dec_reg = {1'b1, R_FILE_SEL};
        else if (addr == A_FILE_DATA)
            dec_reg = {1'b1, R_FILE_DATA};
        else
            dec_reg = 4'h0;
    endfunction

    logic [6:0] fa;
    logic [7:0] src;
    logic [7:0] imm;
    logic [3:0] sub;
    logic dest;
    cid_alu_op_t aop;
    logic [7:0] alu_a;
    logic [7:0] alu_b;
    logic [7:0] alu_res;
    logic alu_c;
    logic alu_dc;
    logic alu_z;
    logic wr_acc;
    logic wr_file;
    logic upd_cdc;
    logic upd_z;
    logic skip;
    logic jump;
    logic push;
    logic kick;
    logic nap;
    logic [12:0] jaddr;

    always_comb
    begin
        fa = s.ir[6:0];
        imm = s.ir[7:0];
        sub = s.ir[11:8];
        dest = s.ir[DEST_BIT];
        src = (fa == FA_PORT) ? PORT_PINS_I : s.file[fa];
        aop = ALU_PASS;
        alu_a = s.acc;
        alu_b = src;
        wr_acc = 1'b0;
        wr_file = 1'b0;
        upd_cdc = 1'b0;
        upd_z = 1'b0;
        skip = 1'b0;
        jump = 1'b0;
        push = 1'b0;
        kick = 1'b0;
        nap = 1'b0;
        jaddr = s.tos;
        case (s.ir[13:12])
            CLS_BYTE:
            begin
                case (sub)
                    SUB_ADD_REG:
                    begin
                        aop = ALU_ADD;
                        wr_acc = !dest;
                        wr_file = dest;
                        upd_cdc = 1'b1;
                        upd_z = 1'b1;
                    end
                    SUB_XOR_REG:
                    begin
                        aop = ALU_XOR;
                        wr_acc = !dest;
                        wr_file = dest;
                        upd_z = 1'b1;
                    end
                    SUB_CTRL:
                    begin
                        if (s.ir == W_RETURN)
                            jump = 1'b1;
                        else if (s.ir == W_INT_EXIT)
                            jump = 1'b1;
                        else if (s.ir == W_STANDBY)
                            nap = 1'b1;
                        else if (s.ir == W_KICK)
                            kick = 1'b1;
                    end
                    default:
                    begin
                        aop = ALU_PASS;
                    end
                endcase
            end
            CLS_BIT:
            begin
                alu_a = src;
                case (s.ir[11:10])
                    BIT_CLEAR:
                    begin
                        aop = ALU_BCLR;
                        wr_file = 1'b1;
                    end
                    BIT_SET:
                    begin
                        aop = ALU_BSET;
                        wr_file = 1'b1;
                    end
                    BIT_SKIP_LOW: skip = !src[s.ir[9:7]];
                    default: skip = src[s.ir[9:7]];
                endcase
            end
            CLS_JUMP:
            begin
                jump = 1'b1;
                push = !s.ir[JUMP_SEL_BIT];
                jaddr = {s.pc[12:11], s.ir[10:0]};
            end
            default:
            begin
                alu_a = imm;
                alu_b = s.acc;
                wr_acc = 1'b1;
                if (sub[3:1] == LIT_ADD)
                begin
                    aop = ALU_ADD;
                    upd_cdc = 1'b1;
                    upd_z = 1'b1;
                end
                else if (sub[3:1] == LIT_SUB)
                begin
                    aop = ALU_SUB;
                    upd_cdc = 1'b1;
                    upd_z = 1'b1;
                end
                else if (sub == LIT_OR)
                begin
                    aop = ALU_OR;
                    upd_z = 1'b1;
                end
                else if (sub == LIT_AND)
                begin
                    aop = ALU_AND;
                    upd_z = 1'b1;
                end
                else if (sub == LIT_XOR)
                begin
                    aop = ALU_XOR;
                    upd_z = 1'b1;
                end
                else if (sub[3:2] == LIT_EXIT)
                    jump = 1'b1;
                else if (sub[3:2] != LIT_MOVE)
                    wr_acc = 1'b0;
            end
        endcase
    end

    cid_alu cid_alu_inst (
        .op_i(aop),
        .a_i(alu_a),
        .b_i(alu_b),
        .bit_i(s.ir[9:7]),
        .res_o(alu_res),
        .c_o(alu_c),
        .dc_o(alu_dc),
        .z_o(alu_z)
    );

    always_comb
    begin
        logic [3:0] widx;
        logic [3:0] ridx;
        logic idle;
        widx = dec_reg(s.wr_addr);
        ridx = dec_reg(HADDR_I);
        idle = (s.st == ST_IDLE);
        next_s = s;
        next_s.wdt = 1'b0;
        next_s.pre = 1'b0;
        next_s.slp = 1'b0;

        // data phase; writes while busy are dropped so state never races
        if (s.wr_pend && idle && widx[3])
        begin
            if (widx[2:0] == R_INSTR)
            begin
                next_s.ir = HWDATA_I[13:0];
                next_s.st = ST_EXEC;
                next_s.ph = 2'h0;
            end
            else if (widx[2:0] == R_ACC)
                next_s.acc = HWDATA_I[7:0];
            else if (widx[2:0] == R_STATUS)
            begin
                next_s.c = HWDATA_I[ST_C];
                next_s.dc = HWDATA_I[ST_DC];
                next_s.z = HWDATA_I[ST_Z];
            end
            else if (widx[2:0] == R_PC)
                next_s.pc = HWDATA_I[12:0];
            else if (widx[2:0] == R_STACK_TOP)
                next_s.tos = HWDATA_I[12:0];
            else if (widx[2:0] == R_FILE_SEL)
                next_s.fsel = HWDATA_I[6:0];
            else if (widx[2:0] == R_FILE_DATA)
                next_s.file[s.fsel] = HWDATA_I[7:0];
        end

        case (s.st)
            ST_EXEC:
            begin
                next_s.ph = s.ph + 2'h1;
                if (s.ph == Q_LAST)
                begin
                    if (wr_acc)
                        next_s.acc = alu_res;
                    if (wr_file)
                        next_s.file[fa] = alu_res;
                    // timer write restarts its prescaler only when assigned
                    next_s.pre = wr_file && (fa == FA_TIMER_ZERO)
                        && PRESCALER_ON_TIMER_I;
                    if (upd_cdc)
                    begin
                        next_s.c = alu_c;
                        next_s.dc = alu_dc;
                    end
                    if (upd_z)
                        next_s.z = alu_z;
                    if (kick)
                    begin
                        next_s.expiry = 1'b1;
                        next_s.sleep_entry = 1'b1;
                        next_s.wdt = 1'b1;
                    end
                    if (nap)
                    begin
                        next_s.expiry = 1'b1;
                        next_s.sleep_entry = 1'b0;
                        next_s.wdt = 1'b1;
                        next_s.slp = 1'b1;
                    end
                    if (push)
                        next_s.tos = s.pc + 13'h0001;
                    if (jump)
                        next_s.pc = jaddr;
                    else if (skip)
                        next_s.pc = s.pc + 13'h0002;
                    else
                        next_s.pc = s.pc + 13'h0001;
                    next_s.st = (jump || skip) ? ST_FLUSH : ST_IDLE;
                end
            end
            ST_FLUSH:
            begin
                // the discarded word costs a full idle instruction cycle
                next_s.ph = s.ph + 2'h1;
                if (s.ph == Q_LAST)
                    next_s.st = ST_IDLE;
            end
            default:
            begin
                next_s.ph = 2'h0;
            end
        endcase

        // address phase; read data taken from the updated state
        next_s.wr_pend = 1'b0;
        if (HSEL_I && HTRANS_I[1] && HREADY_I)
        begin
            next_s.wr_pend = HWRITE_I;
            next_s.wr_addr = HADDR_I;
            next_s.rdata = 32'h0000_0000;
            if (!HWRITE_I && ridx[3])
            begin
                if (ridx[2:0] == R_INSTR)
                    next_s.rdata[13:0] = next_s.ir;
                else if (ridx[2:0] == R_ACC)
                    next_s.rdata[7:0] = next_s.acc;
                else if (ridx[2:0] == R_STATUS)
                begin
                    next_s.rdata[ST_C] = next_s.c;
                    next_s.rdata[ST_DC] = next_s.dc;
                    next_s.rdata[ST_Z] = next_s.z;
                    next_s.rdata[ST_PD] = next_s.sleep_entry;
                    next_s.rdata[ST_TO] = next_s.expiry;
                    next_s.rdata[ST_BUSY] = (next_s.st != ST_IDLE);
                end
                else if (ridx[2:0] == R_PC)
                    next_s.rdata[12:0] = next_s.pc;
                else if (ridx[2:0] == R_STACK_TOP)
                    next_s.rdata[12:0] = next_s.tos;
                else if (ridx[2:0] == R_FILE_SEL)
                    next_s.rdata[6:0] = next_s.fsel;
                else if (ridx[2:0] == R_FILE_DATA)
                    next_s.rdata[7:0] = next_s.file[next_s.fsel];
            end
        end
    end

    always_ff @(posedge CLK_I)
    begin
        if (!RST_B_I)
            s <= RESET_STATE;
        else
            s <= next_s;
    end

    // zero wait states; hsize is not checked since only words are used
    assign HREADYOUT_O = 1'b1;
    assign HRESP_O = 1'b0;
    assign HRDATA_O = s.rdata;
    assign PORT_LATCH_O = s.file[FA_PORT];
    assign WDT_RESTART_O = s.wdt;
    assign PRESCALER_CLEAR_O = s.pre;
    assign SLEEP_O = s.slp;
    assign BUSY_O = (s.st != ST_IDLE);

endmodule

// file: verilog/cid_pkg.sv
/*
 * Shared constants and types for the instruction decode and execute block:
 * opcode fields, file addresses, bus register offsets and status bit layout.
 * Assumes a single 200 MHz clock and an AHB-Lite master for software access.
 */
// How it works
// - add immediate into accumulator, flags C DC Z
// - bit clear in file register, flags untouched
// - bit set in file register, flags untouched
// - add register, destination bit picks target
// - port source read from pins, not latch
// - timer count write clears assigned prescaler
// - taken branch or skip costs two cycles
// - skip next when tested bit low
// - skip next when tested bit high
// - standby entry updates expiry and sleep flags
// - watchdog kick restarts watchdog, updates flags
// - return reloads counter from stack top
// - interrupt exit restores counter from stack
// - exit with immediate loads accumulator, returns
// - immediate minus accumulator, flags C DC Z
// - or immediate into accumulator, zero only
// - xor register by destination, zero flag
// - instruction cycle is four clocks
// - destination zero accumulator, one register
package cid_pkg;

    localparam int unsigned Q_PER_CYCLE = 4;
    localparam logic [1:0] Q_LAST = 2'h3;

    localparam logic [1:0] CLS_BYTE = 2'h0;
    localparam logic [1:0] CLS_BIT = 2'h1;
    localparam logic [1:0] CLS_JUMP = 2'h2;
    localparam logic [1:0] CLS_LIT = 2'h3;

    localparam logic [3:0] SUB_CTRL = 4'h0;
    localparam logic [3:0] SUB_XOR_REG = 4'h6;
    localparam logic [3:0] SUB_ADD_REG = 4'h7;

    localparam logic [1:0] BIT_CLEAR = 2'h0;
    localparam logic [1:0] BIT_SET = 2'h1;
    localparam logic [1:0] BIT_SKIP_LOW = 2'h2;
    localparam logic [1:0] BIT_SKIP_HIGH = 2'h3;

    localparam logic [2:0] LIT_ADD = 3'h7;
    localparam logic [2:0] LIT_SUB = 3'h6;
    localparam logic [3:0] LIT_OR = 4'h8;
    localparam logic [3:0] LIT_AND = 4'h9;
    localparam logic [3:0] LIT_XOR = 4'ha;
    localparam logic [1:0] LIT_MOVE = 2'h0;
    localparam logic [1:0] LIT_EXIT = 2'h1;

    localparam logic [13:0] W_RETURN = 14'h0008;
    localparam logic [13:0] W_INT_EXIT = 14'h0009;
    localparam logic [13:0] W_STANDBY = 14'h0063;
    localparam logic [13:0] W_KICK = 14'h0064;

    localparam int unsigned DEST_BIT = 7;
    localparam int unsigned JUMP_SEL_BIT = 11;

    localparam logic [6:0] FA_TIMER_ZERO = 7'h01;
    localparam logic [6:0] FA_PORT = 7'h05;

    localparam logic [7:0] A_INSTR = 8'h00;
    localparam logic [7:0] A_ACC = 8'h04;
    localparam logic [7:0] A_STATUS = 8'h08;
    localparam logic [7:0] A_PC = 8'h0c;
    localparam logic [7:0] A_STACK_TOP = 8'h10;
    localparam logic [7:0] A_FILE_SEL = 8'h14;
    localparam logic [7:0] A_FILE_DATA = 8'h18;

    localparam logic [2:0] R_INSTR = 3'h0;
    localparam logic [2:0] R_ACC = 3'h1;
    localparam logic [2:0] R_STATUS = 3'h2;
    localparam logic [2:0] R_PC = 3'h3;
    localparam logic [2:0] R_STACK_TOP = 3'h4;
    localparam logic [2:0] R_FILE_SEL = 3'h5;
    localparam logic [2:0] R_FILE_DATA = 3'h6;

    localparam int unsigned ST_C = 0;
    localparam int unsigned ST_DC = 1;
    localparam int unsigned ST_Z = 2;
    localparam int unsigned ST_PD = 3;
    localparam int unsigned ST_TO = 4;
    localparam int unsigned ST_BUSY = 8;

    localparam logic RST_EXPIRY = 1'b1;
    localparam logic RST_SLEEP_ENTRY = 1'b1;

    typedef enum logic [2:0] {
        ALU_ADD = 3'b000,
        ALU_SUB = 3'b001,
        ALU_AND = 3'b010,
        ALU_OR = 3'b011,
        ALU_XOR = 3'b100,
        ALU_BCLR = 3'b101,
        ALU_BSET = 3'b110,
        ALU_PASS = 3'b111
    } cid_alu_op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_FLUSH = 2'b10
    } cid_state_t;

endpackage
